/* design/spims_top.sv */
// Serial master/slave port with byte register file
// Overview of operation
// RULE1: Wait with clock-stop clear runs normally; set, master clock halts.
// RULE2: Slave keeps shifting through wait and stop, tracking external clock.
// RULE3: Master in stop or stopped wait freezes transfer, resumes on return.
// RULE4: MOSI drives data as master, is sampled as slave.
// RULE5: MISO drives data as slave, is sampled as master.
// RULE6: Master may drive select out; slave takes select as input.
// RULE7: Master generates serial clock; slave shifts on external clock.
// RULE8: Reserved bits read zero; writes to them do nothing.
// RULE9: Control bit 7 gates interrupt from done or fault flag.
// RULE10: Control bit 6 enables port; clearing idles it, resets flags.
// RULE11: Control bit 5 gates interrupt from transmit-empty flag.
// RULE12: Control bit 4 picks master; any change forces idle.
// RULE13: Control bit 3 sets clock idle level, low or high.
// RULE14: Control bit 2 picks sampling on odd or even edges.
// RULE15: Master aborts transfer when clock, select or order settings change.
// RULE16: Control bit 0 picks bit order; data register keeps MSB high.
// RULE17: Select pin use depends on mode, fault detect and output enable.
// RULE18: Width control picks 8-bit low byte or 16-bit word.
// RULE19: Bidir mode shares one data line, driven per output enable.
// RULE20: Master clock rate is bus clock over baud divisor.
// RULE21: Divisor is (preselect plus one) times two to (select plus one).
// RULE22: Done flag sets at frame end; empty flag when buffer free.
`timescale 1ns/1ps
module spims_top (
	input  wire logic       CORE_CLK_IN,
	input  wire logic       ARST_N_IN,
	input  wire logic [2:0] ADDR_IN,
	input  wire logic [7:0] WDATA_IN,
	input  wire logic       WR_IN,
	input  wire logic       RD_IN,
	output logic      [7:0] RDATA_OUT,
	input  wire logic       WAIT_MODE_IN,
	input  wire logic       STOP_MODE_IN,
	output logic            IRQ_OUT,
	input  wire logic       SCK_IN,
	output logic            SCK_OUT,
	output logic            SCK_OE_OUT,
	input  wire logic       MOSI_IN,
	output logic            MOSI_OUT,
	output logic            MOSI_OE_OUT,
	input  wire logic       MISO_IN,
	output logic            MISO_OUT,
	output logic            MISO_OE_OUT,
	input  wire logic       SS_N_IN,
	output logic            SS_N_OUT,
	output logic            SS_N_OE_OUT
);

	spims_pkg::spims_ctrl_one_s ctrl_one, next_ctrl_one;
	logic [7:0]                 ctrl_two, next_ctrl_two;
	logic [7:0]                 baud, next_baud;
	logic [15:0]                tx_buf, next_tx_buf;
	logic [15:0]                tx_sh, next_tx_sh;
	logic [15:0]                rx_sh, next_rx_sh;
	logic [15:0]                rx_buf, next_rx_buf;
	logic                       tx_empty, next_tx_empty;
	logic                       done_flag, next_done_flag;
	logic                       fault_flag, next_fault_flag;
	logic                       done_armed, next_done_armed;
	logic                       fault_armed, next_fault_armed;
	logic [4:0]                 cnt, next_cnt;
	logic [spims_pkg::BAUD_CNT_W-1:0] baud_cnt, next_baud_cnt;
	logic                       sck_lvl, next_sck_lvl;
	logic                       out_bit, next_out_bit;
	logic                       sck_prev;
	spims_pkg::spims_state_e    state, next_state;
	spims_pkg::spims_pins_s     pin_out, next_pin_out;
	spims_pkg::spims_pins_s     pin_oe, next_pin_oe;
	logic [7:0]                 rdata, next_rdata;
	logic                       irq, next_irq;

	// Register decode
	wire wr_ctrl_one = WR_IN && ADDR_IN == spims_pkg::OFS_CTRL_ONE;
	wire wr_ctrl_two = WR_IN && ADDR_IN == spims_pkg::OFS_CTRL_TWO;
	wire wr_baud     = WR_IN && ADDR_IN == spims_pkg::OFS_BAUD;
	wire wr_data_hi  = WR_IN && ADDR_IN == spims_pkg::OFS_DATA_HIGH;
	wire wr_data_lo  = WR_IN && ADDR_IN == spims_pkg::OFS_DATA_LOW;
	wire rd_status   = RD_IN && ADDR_IN == spims_pkg::OFS_STATUS;
	wire rd_data_lo  = RD_IN && ADDR_IN == spims_pkg::OFS_DATA_LOW;

	wire enabled   = ctrl_one.port_enable;
	wire is_master = ctrl_one.master_select;
	wire width16   = ctrl_two[spims_pkg::BIT_TRANSFER_WIDTH];
	wire bidir     = ctrl_two[spims_pkg::BIT_BIDIR_MODE];
	wire bidir_oe  = ctrl_two[spims_pkg::BIT_BIDIR_OE];
	wire fault_en  = ctrl_two[spims_pkg::BIT_FAULT_DETECT];
	wire lsb_first = ctrl_one.low_bit_first;
	wire [3:0] last_idx = width16 ? 4'hf : 4'h7;

	// RULE1: master clock halts
	// RULE3: freeze master in low power
	wire halted = is_master && (STOP_MODE_IN ||
		(WAIT_MODE_IN && ctrl_two[spims_pkg::BIT_WAIT_STOP]));

	// RULE21: divisor half per clock edge
	wire [spims_pkg::BAUD_CNT_W-1:0] half_div =
		({8'h00, baud[spims_pkg::BAUD_PRE_HI:spims_pkg::BAUD_PRE_LO]} +
		11'h001) << baud[spims_pkg::BAUD_SEL_HI:spims_pkg::BAUD_SEL_LO];

	// RULE4: MOSI sampled as slave
	// RULE5: MISO sampled as master
	// RULE19: bidir uses the shared line
	wire in_bit = is_master ? (bidir ? MOSI_IN : MISO_IN)
	                        : (bidir ? MISO_IN : MOSI_IN);

	// RULE16: bit order maps to register position
	wire [3:0] samp_idx  = cnt[4:1];
	wire [3:0] samp_pos  = lsb_first ? samp_idx : last_idx - samp_idx;
	wire [3:0] drv_idx   = ctrl_one.clock_phase ? cnt[4:1] :
		cnt[4:1] + 4'h1;
	wire [3:0] drv_pos   = lsb_first ? drv_idx : last_idx - drv_idx;
	wire [3:0] first_pos = lsb_first ? 4'h0 : last_idx;
	// RULE14: sample on odd or even edges
	wire samp_edge = cnt[0] == ctrl_one.clock_phase;
	wire last_edge = cnt == {last_idx, 1'b1};

	// RULE20: master edge from divider
	wire m_edge = enabled && is_master && state == spims_pkg::ST_RUN &&
		!halted && baud_cnt == half_div - 11'h001;
	// RULE2: slave edge ignores low power
	// RULE7: slave shifts on external clock
	wire s_edge = enabled && !is_master && state == spims_pkg::ST_RUN &&
		!SS_N_IN && SCK_IN != sck_prev;
	wire edge_now = m_edge || s_edge;

	// RULE17: select as fault input
	wire mode_fault = enabled && is_master && fault_en &&
		!ctrl_one.select_output_enable && !SS_N_IN;

	// RULE12: master/slave change idles
	// RULE15: setting change aborts master
	wire ctrl_one_chg = wr_ctrl_one && (WDATA_IN[4] != is_master ||
		(is_master && WDATA_IN[3:0] != ctrl_one[3:0]));
	wire ctrl_two_chg = wr_ctrl_two && is_master &&
		(WDATA_IN[6] != ctrl_two[6] || WDATA_IN[4] != ctrl_two[4] ||
		WDATA_IN[0] != ctrl_two[0] ||
		(bidir && WDATA_IN[3] != ctrl_two[3]));
	wire baud_chg = wr_baud && is_master &&
		(WDATA_IN & spims_pkg::BAUD_MASK) != baud;
	wire cfg_abort = ctrl_one_chg || ctrl_two_chg || baud_chg || mode_fault;

	// RULE8: reserved bits read zero
	wire [7:0] status_val = {done_flag, 1'b0, tx_empty, fault_flag, 4'h0};
	wire [7:0] rd_val =
		ADDR_IN == spims_pkg::OFS_CTRL_ONE  ? ctrl_one :
		ADDR_IN == spims_pkg::OFS_CTRL_TWO  ? ctrl_two :
		ADDR_IN == spims_pkg::OFS_BAUD      ? baud :
		ADDR_IN == spims_pkg::OFS_STATUS    ? status_val :
		ADDR_IN == spims_pkg::OFS_DATA_HIGH ?
			(width16 ? rx_buf[15:8] : 8'h00) :
		ADDR_IN == spims_pkg::OFS_DATA_LOW  ? rx_buf[7:0] : 8'h00;

	always_comb begin
		next_ctrl_one    = ctrl_one;
		next_ctrl_two    = ctrl_two;
		next_baud        = baud;
		next_tx_buf      = tx_buf;
		next_tx_sh       = tx_sh;
		next_rx_sh       = rx_sh;
		next_rx_buf      = rx_buf;
		next_tx_empty    = tx_empty;
		next_done_flag   = done_flag;
		next_fault_flag  = fault_flag;
		next_done_armed  = done_armed;
		next_fault_armed = fault_armed;
		next_cnt         = cnt;
		next_baud_cnt    = baud_cnt;
		next_sck_lvl     = sck_lvl;
		next_out_bit     = out_bit;
		next_state       = state;

		// RULE8: writes to reserved bits dropped
		if (wr_ctrl_one) begin
			next_ctrl_one = WDATA_IN;
		end
		if (wr_ctrl_two) begin
			next_ctrl_two = WDATA_IN & spims_pkg::CTRL_TWO_MASK;
		end
		if (wr_baud) begin
			next_baud = WDATA_IN & spims_pkg::BAUD_MASK;
		end

		// Flag clears come before sets so an event wins
		if (rd_status) begin
			next_done_armed  = done_flag;
			next_fault_armed = fault_flag;
		end
		if (rd_data_lo && done_armed) begin
			next_done_flag  = 1'b0;
			next_done_armed = 1'b0;
		end
		if (wr_ctrl_one && fault_armed) begin
			next_fault_flag  = 1'b0;
			next_fault_armed = 1'b0;
		end

		case (state)
			spims_pkg::ST_IDLE: begin
				next_cnt      = 5'h00;
				next_baud_cnt = '0;
				next_sck_lvl  = 1'b0;
				// Master start waits for a queued word
				if (enabled && is_master && !tx_empty && !halted) begin
					next_state    = spims_pkg::ST_RUN;
					next_tx_sh    = tx_buf;
					next_tx_empty = 1'b1;
					next_out_bit  = tx_buf[first_pos];
					next_rx_sh    = 16'h0000;
				end else if (enabled && !is_master && !SS_N_IN) begin
					// Slave resends the old word when none is queued
					next_state = spims_pkg::ST_RUN;
					next_rx_sh = 16'h0000;
					if (!tx_empty) begin
						next_tx_sh    = tx_buf;
						next_tx_empty = 1'b1;
						next_out_bit  = tx_buf[first_pos];
					end else begin
						next_out_bit = tx_sh[first_pos];
					end
				end
			end
			spims_pkg::ST_RUN: begin
				if (m_edge) begin
					next_baud_cnt = '0;
				end else if (is_master && !halted) begin
					next_baud_cnt = baud_cnt + 11'h001;
				end
				if (edge_now) begin
					next_sck_lvl = ~sck_lvl;
					next_cnt     = cnt + 5'h01;
					if (samp_edge) begin
						next_rx_sh[samp_pos] = in_bit;
					end else if (!last_edge) begin
						next_out_bit = tx_sh[drv_pos];
					end
					if (last_edge) begin
						// RULE22: frame done sets flag
						// RULE18: narrow frame leaves high byte zero
						next_rx_buf    = next_rx_sh;
						next_done_flag = 1'b1;
						next_cnt       = 5'h00;
						next_sck_lvl   = 1'b0;
						next_rx_sh     = 16'h0000;
						if (is_master) begin
							next_state = spims_pkg::ST_IDLE;
						end else if (!tx_empty) begin
							next_tx_sh    = tx_buf;
							next_tx_empty = 1'b1;
							next_out_bit  = tx_buf[first_pos];
						end else begin
							next_out_bit = tx_sh[first_pos];
						end
					end
				end
				// Select release ends a slave frame early
				if (!is_master && SS_N_IN) begin
					next_state = spims_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = spims_pkg::ST_IDLE;
			end
		endcase

		// RULE22: free buffer shows empty
		if (wr_data_hi) begin
			next_tx_buf[15:8] = WDATA_IN;
		end
		if (wr_data_lo) begin
			next_tx_buf[7:0] = WDATA_IN;
			next_tx_empty    = 1'b0;
		end

		// RULE17: fault drops to slave
		if (mode_fault) begin
			next_fault_flag             = 1'b1;
			next_ctrl_one.master_select = 1'b0;
		end

		// RULE15: abort returns to idle
		if (cfg_abort) begin
			next_state   = spims_pkg::ST_IDLE;
			next_cnt     = 5'h00;
			next_sck_lvl = 1'b0;
		end

		// RULE10: disable idles and resets flags
		if (!enabled) begin
			next_state       = spims_pkg::ST_IDLE;
			next_cnt         = 5'h00;
			next_sck_lvl     = 1'b0;
			next_done_flag   = 1'b0;
			next_fault_flag  = 1'b0;
			next_tx_empty    = 1'b1;
			next_done_armed  = 1'b0;
			next_fault_armed = 1'b0;
		end
	end

	// Pin drive, computed from next state so pins follow it exactly
	wire next_en     = next_ctrl_one.port_enable;
	wire next_master = next_ctrl_one.master_select;
	wire next_bidir  = next_ctrl_two[spims_pkg::BIT_BIDIR_MODE];
	wire next_boe    = next_ctrl_two[spims_pkg::BIT_BIDIR_OE];
	wire next_busy   = next_state == spims_pkg::ST_RUN;

	always_comb begin
		// RULE7: master drives serial clock
		// RULE13: polarity sets idle level
		next_pin_out.sck  = next_ctrl_one.clock_polarity ^ next_sck_lvl;
		next_pin_oe.sck   = next_en && next_master;
		// RULE4: MOSI driven as master
		next_pin_out.mosi = next_out_bit;
		next_pin_oe.mosi  = next_en && next_master &&
			(!next_bidir || next_boe);
		// RULE5: MISO driven as selected slave
		// RULE19: bidir enable gates the line
		next_pin_out.miso = next_out_bit;
		next_pin_oe.miso  = next_en && !next_master && !SS_N_IN &&
			(!next_bidir || next_boe);
		// RULE6: select out only as master
		// RULE17: driven only with fault detect and output enable
		next_pin_out.ss_n = !next_busy;
		next_pin_oe.ss_n  = next_en && next_master &&
			next_ctrl_two[spims_pkg::BIT_FAULT_DETECT] &&
			next_ctrl_one.select_output_enable;
	end

	assign next_rdata = RD_IN ? rd_val : 8'h00;

	// RULE9: done or fault interrupt
	// RULE11: transmit-empty interrupt
	assign next_irq =
		(next_ctrl_one.frame_irq_enable && (next_done_flag || next_fault_flag)) ||
		(next_ctrl_one.tx_empty_irq_enable && next_tx_empty && next_en);

	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ctrl_one    <= spims_pkg::CTRL_ONE_RST;
			ctrl_two    <= spims_pkg::CTRL_TWO_RST;
			baud        <= spims_pkg::BAUD_RST;
			tx_buf      <= 16'h0000;
			tx_sh       <= 16'h0000;
			rx_sh       <= 16'h0000;
			rx_buf      <= 16'h0000;
			tx_empty    <= 1'b1;
			done_flag   <= 1'b0;
			fault_flag  <= 1'b0;
			done_armed  <= 1'b0;
			fault_armed <= 1'b0;
			cnt         <= 5'h00;
			baud_cnt    <= '0;
			sck_lvl     <= 1'b0;
			out_bit     <= 1'b0;
			state       <= spims_pkg::ST_IDLE;
		end else begin
			ctrl_one    <= next_ctrl_one;
			ctrl_two    <= next_ctrl_two;
			baud        <= next_baud;
			tx_buf      <= next_tx_buf;
			tx_sh       <= next_tx_sh;
			rx_sh       <= next_rx_sh;
			rx_buf      <= next_rx_buf;
			tx_empty    <= next_tx_empty;
			done_flag   <= next_done_flag;
			fault_flag  <= next_fault_flag;
			done_armed  <= next_done_armed;
			fault_armed <= next_fault_armed;
			cnt         <= next_cnt;
			baud_cnt    <= next_baud_cnt;
			sck_lvl     <= next_sck_lvl;
			out_bit     <= next_out_bit;
			state       <= next_state;
		end
	end

	// Pin and bus outputs, all registered
	always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sck_prev <= 1'b0;
			pin_out  <= 4'h1;
			pin_oe   <= 4'h0;
			rdata    <= 8'h00;
			irq      <= 1'b0;
		end else begin
			sck_prev <= SCK_IN;
			pin_out  <= next_pin_out;
			pin_oe   <= next_pin_oe;
			rdata    <= next_rdata;
			irq      <= next_irq;
		end
	end

	assign RDATA_OUT   = rdata;
	assign IRQ_OUT     = irq;
	assign SCK_OUT     = pin_out.sck;
	assign SCK_OE_OUT  = pin_oe.sck;
	assign MOSI_OUT    = pin_out.mosi;
	assign MOSI_OE_OUT = pin_oe.mosi;
	assign MISO_OUT    = pin_out.miso;
	assign MISO_OE_OUT = pin_oe.miso;
	assign SS_N_OUT    = pin_out.ss_n;
	assign SS_N_OE_OUT = pin_oe.ss_n;

endmodule // spims_top

/* design/spims_pkg.sv */
// Shared constants and types for the serial master/slave port
package spims_pkg;

	// Register offsets
	localparam logic [2:0] OFS_CTRL_ONE   = 3'h0;
	localparam logic [2:0] OFS_CTRL_TWO   = 3'h1;
	localparam logic [2:0] OFS_BAUD       = 3'h2;
	localparam logic [2:0] OFS_STATUS     = 3'h3;
	localparam logic [2:0] OFS_DATA_HIGH  = 3'h4;
	localparam logic [2:0] OFS_DATA_LOW   = 3'h5;

	// Control two fields
	localparam int BIT_TRANSFER_WIDTH = 6;
	localparam int BIT_FAULT_DETECT   = 4;
	localparam int BIT_BIDIR_OE       = 3;
	localparam int BIT_WAIT_STOP      = 1;
	localparam int BIT_BIDIR_MODE     = 0;

	// Baud fields
	localparam int BAUD_PRE_HI = 6;
	localparam int BAUD_PRE_LO = 4;
	localparam int BAUD_SEL_HI = 2;
	localparam int BAUD_SEL_LO = 0;

	// Status fields
	localparam int BIT_DONE_FLAG  = 7;
	localparam int BIT_TX_EMPTY   = 5;
	localparam int BIT_FAULT_FLAG = 4;

	// Implemented bits
	localparam logic [7:0] CTRL_TWO_MASK = 8'h5b;
	localparam logic [7:0] BAUD_MASK     = 8'h77;

	// Reset values
	localparam logic [7:0] CTRL_ONE_RST = 8'h04;
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] BAUD_RST     = 8'h00;

	// Divider counter width, covers divisor half of 1024
	localparam int BAUD_CNT_W = 11;

	typedef struct packed {
		logic frame_irq_enable;
		logic port_enable;
		logic tx_empty_irq_enable;
		logic master_select;
		logic clock_polarity;
		logic clock_phase;
		logic select_output_enable;
		logic low_bit_first;
	} spims_ctrl_one_s;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} spims_pins_s;

	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} spims_state_e;

endpackage

/* test/spims_assertions.sv */
// Port-level checks for the serial port
`timescale 1ns/1ps
module spims_assertions (
	input wire logic       CORE_CLK_IN,
	input wire logic       ARST_N_IN,
	input wire logic [2:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic       WR_IN,
	input wire logic       RD_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic       STOP_MODE_IN,
	input wire logic       IRQ_OUT,
	input wire logic       SCK_OUT,
	input wire logic       SCK_OE_OUT,
	input wire logic       MOSI_OE_OUT,
	input wire logic       MISO_OE_OUT,
	input wire logic       SS_N_OE_OUT
);
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);
	property p_rsvd;
		RD_IN && ADDR_IN[2:1] == 2'b11 |=> RDATA_OUT == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved read not zero");
	property p_mask;
		WR_IN && ADDR_IN == spims_pkg::OFS_CTRL_TWO ##1 !WR_IN ##1
			RD_IN && ADDR_IN == spims_pkg::OFS_CTRL_TWO |=>
			RDATA_OUT == ($past(WDATA_IN, 3) & spims_pkg::CTRL_TWO_MASK);
	endproperty
	a_mask: assert property (p_mask)
		else $error("control two readback wrong");
	// Two samples so the halt has reached the divider
	property p_stop;
		// Master only, a slave keeps shifting in stop
		(STOP_MODE_IN && SCK_OE_OUT) [*2] |-> $stable(SCK_OUT);
	endproperty
	a_stop: assert property (p_stop)
		else $error("clock moved in stop");
	property p_off;
		WR_IN && ADDR_IN == spims_pkg::OFS_CTRL_ONE && !WDATA_IN[6] |-> ##2
			!(SCK_OE_OUT | MOSI_OE_OUT | MISO_OE_OUT | SS_N_OE_OUT);
	endproperty
	a_off: assert property (p_off)
		else $error("pins driven while disabled");
	property p_irq;
		WR_IN && ADDR_IN == spims_pkg::OFS_CTRL_ONE && !WDATA_IN[7] &&
			!WDATA_IN[5] |-> ##2 !IRQ_OUT;
	endproperty
	a_irq: assert property (p_irq)
		else $error("request with enables clear");
	property p_mosi;
		MOSI_OE_OUT |-> SCK_OE_OUT;
	endproperty
	a_mosi: assert property (p_mosi)
		else $error("mosi driven as slave");
	property p_miso;
		MISO_OE_OUT |-> !SCK_OE_OUT && !SS_N_OE_OUT;
	endproperty
	a_miso: assert property (p_miso)
		else $error("miso driven as master");
	property p_ss;
		SS_N_OE_OUT |-> SCK_OE_OUT;
	endproperty
	a_ss: assert property (p_ss)
		else $error("select driven as slave");
endmodule // spims_assertions
bind spims_top spims_assertions u_chk (
	.CORE_CLK_IN (CORE_CLK_IN),
	.ARST_N_IN   (ARST_N_IN),
	.ADDR_IN     (ADDR_IN),
	.WDATA_IN    (WDATA_IN),
	.WR_IN       (WR_IN),
	.RD_IN       (RD_IN),
	.RDATA_OUT   (RDATA_OUT),
	.STOP_MODE_IN(STOP_MODE_IN),
	.IRQ_OUT     (IRQ_OUT),
	.SCK_OUT     (SCK_OUT),
	.SCK_OE_OUT  (SCK_OE_OUT),
	.MOSI_OE_OUT (MOSI_OE_OUT),
	.MISO_OE_OUT (MISO_OE_OUT),
	.SS_N_OE_OUT (SS_N_OE_OUT)
);

/* test/spims_partner.sv */
// Far-end serial slave model for master frames
`timescale 1ns/1ps
module spims_partner (
	input  wire logic        sck_in,
	input  wire logic        mosi_in,
	input  wire logic        ss_n_in,
	input  wire logic        clock_phase_in,
	input  wire logic        lsb_in,
	input  wire logic        wide_in,
	input  wire logic [15:0] tx_word_in,
	output logic             miso_out,
	output logic      [15:0] rx_word_out
);
	int edge_cnt = 0;
	int n        = 8;
	function automatic int pos(input int k);
		return lsb_in ? k : n - 1 - k;
	endfunction
	initial miso_out = 1'b1;
	always @(negedge ss_n_in) begin
		edge_cnt = 0;
		n = wide_in ? 16 : 8;
		rx_word_out = 16'h0000;
		if (!clock_phase_in)
			miso_out = tx_word_in[pos(0)];
	end
	// Released line flips, stale bits never match
	always @(posedge ss_n_in)
		miso_out = ~miso_out;
	always @(sck_in) begin
		// Select may rise in the same step as the last edge
		if (edge_cnt < 2 * n && (!ss_n_in || edge_cnt == 2 * n - 1)) begin
			edge_cnt++;
			if (edge_cnt % 2 != int'(clock_phase_in))
				rx_word_out[pos((edge_cnt - 1) / 2)] = mosi_in;
			else if (edge_cnt / 2 < n)
				miso_out = tx_word_in[pos(edge_cnt / 2)];
		end
	end
endmodule // spims_partner

/* test/test_spims_top.sv */
// Bench for the serial master/slave port
`timescale 1ns/1ps
module test_spims_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  adr = 3'h0;
	logic [7:0]  wd = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        wm = 1'b0;
	logic        sm = 1'b0;
	logic        t_sck = 1'b0;
	logic        t_mosi = 1'b0;
	logic        t_ss_n = 1'b1;
	logic        slv = 1'b0;
	logic [7:0]  c1 = 8'h00;
	logic [7:0]  c2 = 8'h00;
	logic [15:0] p_tx = 16'h0000;
	logic [15:0] p_rx;
	logic [7:0]  rdat;
	logic        irq, sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e;
	logic        ss_o, ss_e, p_miso, sck_w, mosi_w, miso_w, ss_w;
	int          failures = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          edges[$];
	logic [2:0]  ra [5] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [7:0]  re [5] = '{8'h5b, 8'h77, 8'h20, 8'h00, 8'h00};
	// Fields: control one, control two, baud, word, wait, stop
	logic [41:0] plan [9] = '{
		{8'h52, 8'h10, 8'h00, 16'h00a5, 2'b00},
		{8'h5a, 8'h10, 8'h00, 16'h003c, 2'b00},
		{8'hd6, 8'h10, 8'h01, 16'h0081, 2'b00},
		{8'h7f, 8'h10, 8'h10, 16'h00c4, 2'b00},
		{8'h53, 8'h50, 8'h11, 16'hb3c1, 2'b00},
		{8'h5e, 8'h50, 8'h23, 16'h1234, 2'b00},
		{8'h52, 8'h12, 8'h11, 16'h00e7, 2'b10},
		{8'h52, 8'h10, 8'h11, 16'h0019, 2'b10},
		{8'h52, 8'h10, 8'h11, 16'h006e, 2'b01}};
	// Pins resolved from all drivers
	assign sck_w  = sck_e ? sck_o : t_sck;
	assign mosi_w = mosi_e ? mosi_o : t_mosi;
	assign miso_w = miso_e ? miso_o : p_miso;
	assign ss_w   = ss_e ? ss_o : t_ss_n;
	initial forever #25 clk = ~clk;
	always @(posedge clk) cyc++;
	// Count by clock drive, select rises with the last edge
	always @(sck_w) if (sck_e && !slv) edges.push_back(cyc);
	spims_top uut (
		.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .ADDR_IN(adr),
		.WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat),
		.WAIT_MODE_IN(wm), .STOP_MODE_IN(sm), .IRQ_OUT(irq),
		.SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_e),
		.MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_e),
		.MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE_OUT(miso_e),
		.SS_N_IN(ss_w), .SS_N_OUT(ss_o), .SS_N_OE_OUT(ss_e));
	spims_partner far_end (
		.sck_in(sck_w), .mosi_in(mosi_w), .ss_n_in(ss_w | slv),
		.clock_phase_in(c1[2]), .lsb_in(c1[0]), .wide_in(c2[6]),
		.tx_word_in(p_tx), .miso_out(p_miso), .rx_word_out(p_rx));
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd_reg(a, v);
		check({8'h00, v}, {8'h00, exp});
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
	initial begin
		logic [7:0]  st;
		logic [7:0]  got;
		logic [7:0]  bd;
		logic [15:0] tx;
		logic [15:0] mk;
		logic [1:0]  ws;
		int          h;
		int          n0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		check_reg(3'h0, 8'h04);
		check_reg(3'h3, 8'h20);
		for (int i = 0; i < 5; i++) begin
			wr_reg(ra[i], 8'hff);
			check_reg(ra[i], re[i]);
		end
		for (int k = 0; k < 9; k++) begin
			{c1, c2, bd, tx, ws} = plan[k];
			h = (int'(bd[6:4]) + 1) << bd[2:0];
			mk = c2[6] ? 16'hffff : 16'h00ff;
			wr_reg(3'h2, bd);
			wr_reg(3'h0, c1);
			wr_reg(3'h1, c2);
			repeat (2) @(posedge clk);
			check({14'h0, sck_w, ss_w}, {14'h0, c1[3], 1'b1});
			p_tx = tx ^ 16'h6c39;
			edges.delete();
			if (c2[6])
				wr_reg(3'h4, tx[15:8]);
			wr_reg(3'h5, tx[7:0]);
			if (ws != 2'b00) begin
				repeat (12) @(posedge clk);
				wm <= ws[1];
				sm <= ws[0];
				repeat (30) @(posedge clk);
				n0 = edges.size();
				repeat (30) @(posedge clk);
				check(16'(edges.size() != n0), 16'(!(ws[0] | (ws[1] & c2[1]))));
				wm <= 1'b0;
				sm <= 1'b0;
			end
			st = 8'h00;
			for (int i = 0; i < 600 && !st[7]; i++)
				rd_reg(3'h3, st);
			check({8'h00, st}, 16'h00a0);
			check(16'(irq), 16'(c1[7] | c1[5]));
			if (c2[6])
				check_reg(3'h4, p_tx[15:8]);
			check_reg(3'h5, p_tx[7:0]);
			check(p_rx & mk, tx & mk);
			check(16'(edges.size()), 16'(c2[6] ? 32 : 16));
			check(16'(edges[1] - edges[0]), 16'(h));
		end
		wr_reg(3'h1, 8'h11);
		repeat (2) @(posedge clk);
		check(16'(mosi_e), 16'h0000);
		wr_reg(3'h1, 8'h19);
		repeat (2) @(posedge clk);
		check(16'(mosi_e), 16'h0001);
		wr_reg(3'h1, 8'h10);
		wr_reg(3'h5, 8'h5a);
		repeat (12) @(posedge clk);
		c1 = 8'h56;
		wr_reg(3'h0, c1);
		repeat (3) @(posedge clk);
		check({14'h0, sck_w, ss_w}, 16'h0001);
		check_reg(3'h3, 8'h20);
		c1 = 8'hd0;
		wr_reg(3'h0, c1);
		wr_reg(3'h1, 8'h00);
		t_ss_n <= 1'b0;
		repeat (8) @(posedge clk);
		check_reg(3'h3, 8'h20);
		wr_reg(3'h1, 8'h10);
		repeat (8) @(posedge clk);
		check_reg(3'h3, 8'h30);
		check(16'(irq), 16'h0001);
		wr_reg(3'h0, 8'h00);
		check_reg(3'h3, 8'h20);
		check(16'(irq), 16'h0000);
		t_ss_n <= 1'b1;
		c1 = 8'h40;
		wr_reg(3'h0, c1);
		wr_reg(3'h5, 8'h96);
		slv <= 1'b1;
		sm <= 1'b1;
		t_ss_n <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			t_mosi <= 1'(8'h5c >> i);
			repeat (6) @(posedge clk);
			got[i] = miso_w;
			t_sck <= 1'b1;
			repeat (6) @(posedge clk);
			t_sck <= 1'b0;
		end
		repeat (6) @(posedge clk);
		t_ss_n <= 1'b1;
		sm <= 1'b0;
		check({8'h00, got}, 16'h0096);
		check_reg(3'h3, 8'ha0);
		check_reg(3'h5, 8'h5c);
		tally_and_finish();
	end
endmodule // test_spims_top
